// ---- core/jtag_cfg_pkg.sv ----
// Constants, types and timing for the serial configuration port
//////////////////////////////////////////////////////////////////////
package jtag_cfg_pkg;

   localparam int IR_W   = 5;
   localparam int ID_W   = 32;
   localparam int USER_W = 96;
   localparam int CNT_W  = 32;

   typedef logic [IR_W-1:0] instr_t;

   localparam instr_t EXTERNAL_TEST           = 5'h00;
   localparam instr_t SELECT_USER_CONFIG_PATH = 5'h01;
   localparam instr_t ERASE_CONFIG_A          = 5'h02;
   localparam instr_t ERASE_CONFIG_B          = 5'h03;
   localparam instr_t VERIFY_CONFIG_A         = 5'h04;
   localparam instr_t VERIFY_CONFIG_B         = 5'h05;
   localparam instr_t PROGRAM_CONFIG_A        = 5'h06;
   localparam instr_t PROGRAM_CONFIG_B        = 5'h07;
   localparam instr_t START_AUTO_CALIBRATION  = 5'h0C;
   localparam instr_t READ_IDENTIFICATION     = 5'h0D;
   localparam instr_t SAMPLE_PRELOAD          = 5'h1E;
   localparam instr_t BYPASS                  = 5'h1F;

   // Arbitrary identification word
   localparam logic [ID_W-1:0] ID_VALUE = 32'h0F0F_0F01;

   // Bit positions inside configuration A
   localparam int CFG_SELECT_BIT = 95;
   localparam int SECURITY_BIT   = 94;
   // Capacitor bits, the only ones configuration B stores
   localparam logic [USER_W-1:0] CONFIG_B_MASK = 96'h0000_0000_FFFF_FFFF_FFFF_FFFF;

   // Timing
   localparam int CLK_MHZ      = 250;
   localparam int PROG_TIME_MS = 100;
   localparam int CAL_TIME_MS  = 100;
   localparam int PROG_CYCLES  = PROG_TIME_MS * 1000 * CLK_MHZ;
   localparam int CAL_CYCLES   = CAL_TIME_MS * 1000 * CLK_MHZ;

   typedef enum logic [3:0] {
      TAP_RESET      = 4'h0,
      TAP_RUN_IDLE   = 4'h1,
      TAP_SEL_DR     = 4'h2,
      TAP_CAPTURE_DR = 4'h3,
      TAP_SHIFT_DR   = 4'h4,
      TAP_EXIT1_DR   = 4'h5,
      TAP_PAUSE_DR   = 4'h6,
      TAP_EXIT2_DR   = 4'h7,
      TAP_UPDATE_DR  = 4'h8,
      TAP_SEL_IR     = 4'h9,
      TAP_CAPTURE_IR = 4'hA,
      TAP_SHIFT_IR   = 4'hB,
      TAP_EXIT1_IR   = 4'hC,
      TAP_PAUSE_IR   = 4'hD,
      TAP_EXIT2_IR   = 4'hE,
      TAP_UPDATE_IR  = 4'hF
   } tap_state_t;

   typedef enum logic [2:0] {
      NV_NONE      = 3'h0,
      NV_PROGRAM_A = 3'h1,
      NV_PROGRAM_B = 3'h2,
      NV_ERASE_A   = 3'h3,
      NV_ERASE_B   = 3'h4
   } nv_op_t;

endpackage

// ---- core/tap_if.sv ----
// Interface between the port core and its controller state machine
`timescale 1ns/1ps
`default_nettype none
interface tap_if;
   logic                    tck_rise;
   logic                    tms;
   jtag_cfg_pkg::tap_state_t state;

   modport fsm  (input tck_rise, input tms, output state);
   modport core (output tck_rise, output tms, input state);
endinterface
`default_nettype wire

// ---- core/tap_fsm.sv ----
// Test access port controller state machine
`timescale 1ns/1ps
`default_nettype none
module tap_fsm (
   input wire logic clk,
   input wire logic srst,
   tap_if.fsm       port
);
   jtag_cfg_pkg::tap_state_t state_r;
   jtag_cfg_pkg::tap_state_t state_nxt;

   assign port.state = state_r;

   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         jtag_cfg_pkg::TAP_RESET:      state_nxt = port.tms ? jtag_cfg_pkg::TAP_RESET : jtag_cfg_pkg::TAP_RUN_IDLE;
         jtag_cfg_pkg::TAP_RUN_IDLE:   state_nxt = port.tms ? jtag_cfg_pkg::TAP_SEL_DR : jtag_cfg_pkg::TAP_RUN_IDLE;
         jtag_cfg_pkg::TAP_SEL_DR:     state_nxt = port.tms ? jtag_cfg_pkg::TAP_SEL_IR : jtag_cfg_pkg::TAP_CAPTURE_DR;
         jtag_cfg_pkg::TAP_CAPTURE_DR: state_nxt = port.tms ? jtag_cfg_pkg::TAP_EXIT1_DR : jtag_cfg_pkg::TAP_SHIFT_DR;
         jtag_cfg_pkg::TAP_SHIFT_DR:   state_nxt = port.tms ? jtag_cfg_pkg::TAP_EXIT1_DR : jtag_cfg_pkg::TAP_SHIFT_DR;
         jtag_cfg_pkg::TAP_EXIT1_DR:   state_nxt = port.tms ? jtag_cfg_pkg::TAP_UPDATE_DR : jtag_cfg_pkg::TAP_PAUSE_DR;
         jtag_cfg_pkg::TAP_PAUSE_DR:   state_nxt = port.tms ? jtag_cfg_pkg::TAP_EXIT2_DR : jtag_cfg_pkg::TAP_PAUSE_DR;
         jtag_cfg_pkg::TAP_EXIT2_DR:   state_nxt = port.tms ? jtag_cfg_pkg::TAP_UPDATE_DR : jtag_cfg_pkg::TAP_SHIFT_DR;
         jtag_cfg_pkg::TAP_UPDATE_DR:  state_nxt = port.tms ? jtag_cfg_pkg::TAP_SEL_DR : jtag_cfg_pkg::TAP_RUN_IDLE;
         jtag_cfg_pkg::TAP_SEL_IR:     state_nxt = port.tms ? jtag_cfg_pkg::TAP_RESET : jtag_cfg_pkg::TAP_CAPTURE_IR;
         jtag_cfg_pkg::TAP_CAPTURE_IR: state_nxt = port.tms ? jtag_cfg_pkg::TAP_EXIT1_IR : jtag_cfg_pkg::TAP_SHIFT_IR;
         jtag_cfg_pkg::TAP_SHIFT_IR:   state_nxt = port.tms ? jtag_cfg_pkg::TAP_EXIT1_IR : jtag_cfg_pkg::TAP_SHIFT_IR;
         jtag_cfg_pkg::TAP_EXIT1_IR:   state_nxt = port.tms ? jtag_cfg_pkg::TAP_UPDATE_IR : jtag_cfg_pkg::TAP_PAUSE_IR;
         jtag_cfg_pkg::TAP_PAUSE_IR:   state_nxt = port.tms ? jtag_cfg_pkg::TAP_EXIT2_IR : jtag_cfg_pkg::TAP_PAUSE_IR;
         jtag_cfg_pkg::TAP_EXIT2_IR:   state_nxt = port.tms ? jtag_cfg_pkg::TAP_UPDATE_IR : jtag_cfg_pkg::TAP_SHIFT_IR;
         jtag_cfg_pkg::TAP_UPDATE_IR:  state_nxt = port.tms ? jtag_cfg_pkg::TAP_SEL_DR : jtag_cfg_pkg::TAP_RUN_IDLE;
      endcase
   end

   // State advances only on a test clock rise
   always_ff @(posedge clk) begin
      if (srst) begin
         state_r <= jtag_cfg_pkg::TAP_RESET;
      end else if (port.tck_rise) begin
         state_r <= state_nxt;
      end
   end
endmodule
`default_nettype wire

// ---- core/jtag_config_instruction_unit.sv ----
// Instruction decode and execution of the serial configuration port
`timescale 1ns/1ps
`default_nettype none
module jtag_config_instruction_unit #(
   parameter int unsigned PROG_CYCLES = jtag_cfg_pkg::PROG_CYCLES,
   parameter int unsigned CAL_CYCLES  = jtag_cfg_pkg::CAL_CYCLES
) (
   input  wire logic                            clk,
   input  wire logic                            srst,
   input  wire logic                            tck,
   input  wire logic                            tms,
   input  wire logic                            tdi,
   output logic                                 tdo,
   output logic                                 tdo_oe,
   output logic [jtag_cfg_pkg::USER_W-1:0]      config_a,
   output logic [jtag_cfg_pkg::USER_W-1:0]      config_b,
   output logic [jtag_cfg_pkg::IR_W-1:0]        active_instruction,
   output logic                                 outputs_at_reference,
   output logic                                 inputs_disconnected,
   output logic                                 operation_interrupted,
   output logic                                 calibrating
);
   localparam int UW = jtag_cfg_pkg::USER_W;
   localparam int IW = jtag_cfg_pkg::IR_W;
   localparam int DW = jtag_cfg_pkg::ID_W;
   localparam int CW = jtag_cfg_pkg::CNT_W;

   //////////////////////////////////////////////////////////////////
   // Pin synchronisers and test clock edges
   logic [2:0] pin_meta_r;
   logic [2:0] pin_sync_r;
   logic       tck_prev_r;
   logic       tck_rise;
   logic       tck_fall;
   logic       tms_s;
   logic       tdi_s;

   always_ff @(posedge clk) begin
      if (srst) begin
         pin_meta_r <= 3'h0;
         pin_sync_r <= 3'h0;
         tck_prev_r <= 1'b0;
      end else begin
         pin_meta_r <= {tck, tms, tdi};
         pin_sync_r <= pin_meta_r;
         tck_prev_r <= pin_sync_r[2];
      end
   end

   assign tck_rise = pin_sync_r[2] & ~tck_prev_r;
   assign tck_fall = ~pin_sync_r[2] & tck_prev_r;
   assign tms_s    = pin_sync_r[1];
   assign tdi_s    = pin_sync_r[0];

   //////////////////////////////////////////////////////////////////
   // Controller
   tap_if tap ();
   assign tap.tck_rise = tck_rise;
   assign tap.tms      = tms_s;

   tap_fsm u_fsm (
      .clk  (clk),
      .srst (srst),
      .port (tap.fsm)
   );

   jtag_cfg_pkg::tap_state_t state;
   jtag_cfg_pkg::tap_state_t state_prev_r;
   assign state = tap.state;

   wire in_tlr = (state == jtag_cfg_pkg::TAP_RESET);
   wire in_rti = (state == jtag_cfg_pkg::TAP_RUN_IDLE);
   wire cap_ir = tck_rise & (state == jtag_cfg_pkg::TAP_CAPTURE_IR);
   wire sh_ir  = (state == jtag_cfg_pkg::TAP_SHIFT_IR);
   wire upd_ir = tck_rise & (state == jtag_cfg_pkg::TAP_UPDATE_IR);
   wire cap_dr = tck_rise & (state == jtag_cfg_pkg::TAP_CAPTURE_DR);
   wire sh_dr  = (state == jtag_cfg_pkg::TAP_SHIFT_DR);
   wire rti_entry = in_rti & (state_prev_r != jtag_cfg_pkg::TAP_RUN_IDLE);

   always_ff @(posedge clk) begin
      if (srst) begin
         state_prev_r <= jtag_cfg_pkg::TAP_RESET;
      end else begin
         state_prev_r <= state;
      end
   end

   //////////////////////////////////////////////////////////////////
   // Instruction register
   logic [IW-1:0] ir_sh_r;
   logic [IW-1:0] ir_r;

   always_ff @(posedge clk) begin
      if (srst) begin
         ir_sh_r <= jtag_cfg_pkg::READ_IDENTIFICATION;
      end else if (cap_ir) begin
         ir_sh_r <= jtag_cfg_pkg::READ_IDENTIFICATION;
      end else if (tck_rise & sh_ir) begin
         ir_sh_r <= {tdi_s, ir_sh_r[IW-1:1]};
      end
   end

   always_ff @(posedge clk) begin
      if (srst | in_tlr) begin
         ir_r <= jtag_cfg_pkg::READ_IDENTIFICATION;
      end else if (upd_ir) begin
         ir_r <= ir_sh_r;
      end
   end

   assign active_instruction = ir_r;

   // Path selection; every other code takes the bypass bit
   wire sel_id   = (ir_r == jtag_cfg_pkg::READ_IDENTIFICATION);
   wire sel_user = (ir_r == jtag_cfg_pkg::SELECT_USER_CONFIG_PATH);
   wire sel_byp  = ~sel_id & ~sel_user;

   //////////////////////////////////////////////////////////////////
   // Data registers
   logic          byp_r;
   logic [DW-1:0] id_sh_r;
   logic [UW-1:0] user_r;
   logic [UW-1:0] cfg_a_r;
   logic [UW-1:0] cfg_b_r;

   always_ff @(posedge clk) begin
      if (srst) begin
         byp_r <= 1'b0;
      end else if (cap_dr & sel_byp) begin
         byp_r <= 1'b0;
      end else if (tck_rise & sh_dr & sel_byp) begin
         byp_r <= tdi_s;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         id_sh_r <= jtag_cfg_pkg::ID_VALUE;
      end else if (cap_dr & sel_id) begin
         id_sh_r <= jtag_cfg_pkg::ID_VALUE;
      end else if (tck_rise & sh_dr & sel_id) begin
         id_sh_r <= {tdi_s, id_sh_r[DW-1:1]};
      end
   end

   // Verify read-back; a locked part returns zeros, and verify A also returns zeros when B is selected
   wire is_ver_a   = (ir_r == jtag_cfg_pkg::VERIFY_CONFIG_A);
   wire is_ver_b   = (ir_r == jtag_cfg_pkg::VERIFY_CONFIG_B);
   wire ver_load   = rti_entry & (is_ver_a | is_ver_b);
   wire locked     = cfg_a_r[jtag_cfg_pkg::SECURITY_BIT];
   wire ver_a_ok   = ~cfg_a_r[jtag_cfg_pkg::CFG_SELECT_BIT] & ~locked;
   wire [UW-1:0] ver_a_data = ver_a_ok ? cfg_a_r : '0;
   wire [UW-1:0] ver_b_data = locked ? '0 : cfg_b_r;
   wire [UW-1:0] ver_data   = is_ver_a ? ver_a_data : ver_b_data;

   always_ff @(posedge clk) begin
      if (srst) begin
         user_r <= '0;
      end else if (ver_load) begin
         user_r <= ver_data;
      end else if (tck_rise & sh_dr & sel_user) begin
         user_r <= {tdi_s, user_r[UW-1:1]};
      end
   end

   //////////////////////////////////////////////////////////////////
   // Serial output, changed on the falling test clock edge
   logic tdo_r;
   logic tdo_oe_r;
   wire  dr_bit  = sel_id ? id_sh_r[0] : (sel_user ? user_r[0] : byp_r);
   wire  tdo_bit = sh_ir ? ir_sh_r[0] : dr_bit;

   always_ff @(posedge clk) begin
      if (srst) begin
         tdo_r    <= 1'b0;
         tdo_oe_r <= 1'b0;
      end else if (tck_fall) begin
         tdo_r    <= tdo_bit;
         tdo_oe_r <= sh_ir | sh_dr;
      end
   end

   assign tdo    = tdo_r;
   assign tdo_oe = tdo_oe_r;

   //////////////////////////////////////////////////////////////////
   // Non-volatile program and erase
   jtag_cfg_pkg::nv_op_t nv_req;
   jtag_cfg_pkg::nv_op_t nv_op_r;
   logic [CW-1:0]        nv_cnt_r;

   assign nv_req = (ir_r == jtag_cfg_pkg::PROGRAM_CONFIG_A) ? jtag_cfg_pkg::NV_PROGRAM_A :
                   (ir_r == jtag_cfg_pkg::PROGRAM_CONFIG_B) ? jtag_cfg_pkg::NV_PROGRAM_B :
                   (ir_r == jtag_cfg_pkg::ERASE_CONFIG_A)   ? jtag_cfg_pkg::NV_ERASE_A :
                   (ir_r == jtag_cfg_pkg::ERASE_CONFIG_B)   ? jtag_cfg_pkg::NV_ERASE_B :
                                                              jtag_cfg_pkg::NV_NONE;

   wire nv_busy  = (nv_op_r != jtag_cfg_pkg::NV_NONE);
   wire nv_done  = nv_busy & in_rti & (nv_cnt_r == CW'(PROG_CYCLES - 1));
   wire is_erase = (nv_op_r == jtag_cfg_pkg::NV_ERASE_A) | (nv_op_r == jtag_cfg_pkg::NV_ERASE_B);

   always_ff @(posedge clk) begin
      if (srst) begin
         nv_op_r  <= jtag_cfg_pkg::NV_NONE;
         nv_cnt_r <= '0;
      end else if (rti_entry & (nv_req != jtag_cfg_pkg::NV_NONE)) begin
         nv_op_r  <= nv_req;
         nv_cnt_r <= '0;
      end else if (nv_busy & (~in_rti | nv_done)) begin
         nv_op_r  <= jtag_cfg_pkg::NV_NONE;
      end else if (nv_busy) begin
         nv_cnt_r <= nv_cnt_r + 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         cfg_a_r <= '0;
         cfg_b_r <= '0;
      end else if (nv_done) begin
         unique case (nv_op_r)
            jtag_cfg_pkg::NV_PROGRAM_A: cfg_a_r <= cfg_a_r | user_r;
            jtag_cfg_pkg::NV_PROGRAM_B: cfg_b_r <= cfg_b_r | (user_r & jtag_cfg_pkg::CONFIG_B_MASK);
            jtag_cfg_pkg::NV_ERASE_A:   cfg_a_r <= '0;
            jtag_cfg_pkg::NV_ERASE_B:   cfg_b_r <= '0;
            default:                    cfg_a_r <= cfg_a_r;
         endcase
      end
   end

   assign config_a = cfg_a_r;
   assign config_b = cfg_b_r;

   //////////////////////////////////////////////////////////////////
   // Auto-calibration, free of the port once started
   logic          cal_busy_r;
   logic [CW-1:0] cal_cnt_r;
   wire cal_start = rti_entry & (ir_r == jtag_cfg_pkg::START_AUTO_CALIBRATION) & ~cal_busy_r;

   always_ff @(posedge clk) begin
      if (srst) begin
         cal_busy_r <= 1'b0;
         cal_cnt_r  <= '0;
      end else if (cal_start) begin
         cal_busy_r <= 1'b1;
         cal_cnt_r  <= '0;
      end else if (cal_busy_r) begin
         cal_busy_r <= (cal_cnt_r != CW'(CAL_CYCLES - 1));
         cal_cnt_r  <= cal_cnt_r + 1'b1;
      end
   end

   assign calibrating           = cal_busy_r;
   assign outputs_at_reference  = cal_busy_r | is_erase;
   assign inputs_disconnected   = is_erase;
   assign operation_interrupted = nv_busy;

   //////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (srst);

   chk_tlr_ident: assert property (in_tlr |=> ir_r == jtag_cfg_pkg::READ_IDENTIFICATION)
      else $error("identification not selected after reset state");
   chk_capir_ident: assert property (cap_ir |=> ir_sh_r == jtag_cfg_pkg::READ_IDENTIFICATION)
      else $error("Capture-IR did not load identification code");
   chk_update_exec: assert property (upd_ir |=> ir_r == $past(ir_sh_r))
      else $error("Update-IR did not install instruction");
   chk_bypass_shift: assert property (tck_rise && sh_dr && sel_byp |=> byp_r == $past(tdi_s))
      else $error("bypass bit did not take serial input");
   chk_id_capture: assert property (cap_dr && sel_id |=> id_sh_r == jtag_cfg_pkg::ID_VALUE)
      else $error("identification word not captured");
   chk_user_shift: assert property (tck_rise && sh_dr && sel_user && !ver_load
                                    |=> user_r == {$past(tdi_s), $past(user_r[UW-1:1])})
      else $error("user register shift wrong");
   chk_prog_or: assert property (nv_done && nv_op_r == jtag_cfg_pkg::NV_PROGRAM_A
                                 |=> cfg_a_r == ($past(cfg_a_r) | $past(user_r)))
      else $error("program A did not OR user data");
   chk_b_mask: assert property ((cfg_b_r & ~jtag_cfg_pkg::CONFIG_B_MASK) == '0)
      else $error("configuration B holds A-only bits");
   chk_nv_start: assert property ($rose(nv_busy) |-> $past(rti_entry))
      else $error("program began outside idle entry");
   chk_verify_a: assert property (ver_load && is_ver_a && cfg_a_r[jtag_cfg_pkg::CFG_SELECT_BIT]
                                  |=> user_r == '0)
      else $error("verify A returned data with select bit set");
   chk_erase_clear: assert property (nv_done && nv_op_r == jtag_cfg_pkg::NV_ERASE_B |=> cfg_b_r == '0)
      else $error("erase B left bits set");
   chk_erase_hold: assert property (is_erase |-> outputs_at_reference && inputs_disconnected)
      else $error("erase without outputs held");
   chk_cal_hold: assert property (cal_start |=> calibrating && outputs_at_reference [*2])
      else $error("calibration did not hold outputs");
   chk_tdo_fall: assert property (tck_fall |=> tdo == $past(tdo_bit))
      else $error("serial output not updated on falling edge");

   cov_prog_a: cover property (nv_done && nv_op_r == jtag_cfg_pkg::NV_PROGRAM_A);
   cov_verify: cover property (ver_load && is_ver_b);
   cov_cal:    cover property (cal_start);
   cov_ident:  cover property (tck_rise && sh_dr && sel_id);
endmodule
`default_nettype wire

// ---- bench/jtag_host.sv ----
// Serial programmer model driving the test port pins
`timescale 1ns/1ps
`default_nettype none
module jtag_host (
   input  wire logic clk,
   output logic      tck,
   output logic      tms,
   output logic      tdi,
   input  wire logic tdo
);
   initial begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////////
   // One test clock: pins change while low, output taken before the fall
   task automatic tick(input logic m, input logic d, output logic q);
      tms <= m;
      tdi <= d;
      repeat (4) @(posedge clk);
      tck <= 1'b1;
      repeat (4) @(posedge clk);
      q = tdo;
      tck <= 1'b0;
   endtask
   ////////////////////////////////////////////////////////////////////////
   // Five clocks with mode high, then left in reset with clock still
   task automatic reset_tap();
      logic q;
      repeat (5) tick(1'b1, ~tdi, q);
   endtask
   ////////////////////////////////////////////////////////////////////////
   // Full scan from reset or idle, LSB first, ending in idle
   task automatic scan(input logic ir, input int n, input logic [127:0] din,
                       output logic [127:0] dout);
      logic q;
      dout = '0;
      tick(1'b0, 1'b0, q);
      tick(1'b1, 1'b0, q);
      if (ir) tick(1'b1, 1'b0, q);
      tick(1'b0, 1'b0, q);
      tick(1'b0, 1'b0, q);
      for (int i = 0; i < n; i++) begin
         tick(i == n - 1, din[i], q);
         dout[i] = q;
      end
      tick(1'b1, ~din[n-1], q);
      tick(1'b0, din[n-1], q);
   endtask
endmodule
`default_nettype wire

// ---- bench/tb.sv ----
// Self-checking bench for the serial configuration port
`timescale 1ns/1ps
`default_nettype none
module tb;
   localparam int PROG = 40;
   localparam int CAL  = 80;
   localparam logic [39:0] PAT = 40'hA5_C3F0_9E17;
   localparam logic [95:0] D1  = 96'h3A5C_0000_1234_5678_9ABC_DEF0;
   localparam logic [95:0] D2  = 96'h8000_FF00_0000_0000_0000_000F;
   localparam logic [95:0] MB  = jtag_cfg_pkg::CONFIG_B_MASK;
   typedef struct packed {
      logic [4:0]  code;
      logic [39:0] exp;
   } row_t;
   localparam row_t ROWS [5] = '{
      '{5'h00, {PAT[38:0], 1'b0}},
      '{5'h1E, {PAT[38:0], 1'b0}},
      '{5'h1F, {PAT[38:0], 1'b0}},
      '{5'h08, {PAT[38:0], 1'b0}},
      '{5'h0D, {PAT[7:0], jtag_cfg_pkg::ID_VALUE}}};
   logic         clk;
   logic         srst;
   logic         tck;
   logic         tms;
   logic         tdi;
   logic         tdo;
   logic         tdo_oe;
   logic [95:0]  cfg_a;
   logic [95:0]  cfg_b;
   logic [4:0]   instr;
   logic         out_ref;
   logic         in_disc;
   logic         op_int;
   logic         cal;
   logic [127:0] rd;
   logic         q;
   int           n_errors = 0;
   int           comparisons = 0;
   jtag_host u_host (.clk(clk), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));
   jtag_config_instruction_unit #(.PROG_CYCLES(PROG), .CAL_CYCLES(CAL)) u_dut (
      .clk(clk), .srst(srst), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe),
      .config_a(cfg_a), .config_b(cfg_b), .active_instruction(instr), .outputs_at_reference(out_ref),
      .inputs_disconnected(in_disc), .operation_interrupted(op_int), .calibrating(cal));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   ////////////////////////////////////////////////////////////////////////
   // Tasks
   task automatic chk(input logic [127:0] got, input logic [127:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic ir(input logic [4:0] c);
      logic [127:0] d;
      u_host.scan(1'b1, 5, {123'h0, c}, d);
   endtask
   task automatic dr(input int n, input logic [127:0] din);
      u_host.scan(1'b0, n, din, rd);
   endtask
   task automatic summarize();
      if (n_errors == 0 && comparisons > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   initial begin
      #200000;
      n_errors++;
      summarize();
   end
   ////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      srst = 1'b1;
      repeat (3) @(posedge clk);
      srst <= 1'b0;
      repeat (4) @(posedge clk);
      chk(instr, 5'h0D);
      chk(cfg_a, '0);
      chk(cfg_b, '0);
      chk({tdo_oe, out_ref, in_disc, op_int, cal}, '0);
      dr(32, '0);
      chk(rd[31:0], jtag_cfg_pkg::ID_VALUE);
      u_host.scan(1'b1, 5, 128'h1F, rd);
      chk(rd[4:0], 5'h0D);
      foreach (ROWS[i]) begin
         ir(ROWS[i].code);
         chk(instr, ROWS[i].code);
         dr(40, PAT);
         chk(rd[39:0], ROWS[i].exp);
      end
      // User register round trip
      ir(5'h01);
      dr(96, D2);
      dr(96, D1);
      chk(rd[95:0], D2);
      chk({out_ref, in_disc, op_int}, 3'b000);
      // Program A and B
      ir(5'h06);
      repeat (2) @(posedge clk);
      chk({op_int, in_disc}, 2'b10);
      repeat (PROG + 10) @(posedge clk);
      chk({cfg_a, op_int}, {D1, 1'b0});
      ir(5'h07);
      repeat (PROG + 10) @(posedge clk);
      chk(cfg_b, D1 & MB);
      // Erase of B cut short leaves it unchanged
      ir(5'h03);
      ir(5'h1F);
      repeat (PROG + 10) @(posedge clk);
      chk(cfg_b, D1 & MB);
      // Verify A read back
      ir(5'h04);
      chk(op_int, 1'b0);
      ir(5'h01);
      dr(96, '0);
      chk(rd[95:0], D1);
      // Programming only sets bits; select bit then blocks verify A
      dr(96, D2);
      ir(5'h06);
      repeat (PROG + 10) @(posedge clk);
      chk(cfg_a, D1 | D2);
      ir(5'h04);
      ir(5'h01);
      dr(96, '0);
      chk(rd[95:0], '0);
      ir(5'h05);
      ir(5'h01);
      dr(96, '0);
      chk(rd[95:0], D1 & MB);
      // Erase A and B
      ir(5'h02);
      repeat (2) @(posedge clk);
      chk({out_ref, in_disc, op_int}, 3'b111);
      repeat (PROG + 10) @(posedge clk);
      chk({cfg_a, out_ref, in_disc, op_int}, '0);
      ir(5'h03);
      repeat (PROG + 10) @(posedge clk);
      chk(cfg_b, '0);
      // Calibration runs on after the port is reset
      ir(5'h0C);
      repeat (2) @(posedge clk);
      chk({cal, out_ref}, 2'b11);
      u_host.reset_tap();
      chk({cal, instr}, {1'b1, 5'h0D});
      repeat (CAL) @(posedge clk);
      chk({cal, out_ref}, 2'b00);
      // Reset in mid-run aborts a pending program
      ir(5'h06);
      repeat (2) @(posedge clk);
      srst <= 1'b1;
      repeat (3) @(posedge clk);
      srst <= 1'b0;
      repeat (2) @(posedge clk);
      chk(instr, 5'h0D);
      chk({tdo, tdo_oe, out_ref, in_disc, op_int, cal}, '0);
      repeat (PROG + 10) @(posedge clk);
      chk({cfg_a, op_int}, '0);
      // Output enable follows the shift states
      u_host.tick(1'b0, 1'b0, q);
      u_host.tick(1'b1, 1'b0, q);
      u_host.tick(1'b0, 1'b0, q);
      u_host.tick(1'b0, 1'b0, q);
      repeat (4) @(posedge clk);
      chk({tdo_oe, tdo}, {1'b1, jtag_cfg_pkg::ID_VALUE[0]});
      u_host.tick(1'b1, 1'b0, q);
      u_host.tick(1'b1, 1'b0, q);
      u_host.tick(1'b0, 1'b0, q);
      repeat (4) @(posedge clk);
      chk(tdo_oe, 1'b0);
      summarize();
   end
endmodule
`default_nettype wire
